// File: hdl/fcq_pkg.sv
// Shared constants and carriers for the flash query/protect host controller.
// Assumes a single 100 MHz clock; the flash itself is asynchronous.
`default_nettype none
package fcq_pkg;
    localparam int FCQ_ADDR_W = 24;
    localparam int FCQ_CLK_NS = 10;
    // Bus cycle phase times and their cycle counts (least times, rounded up)
    localparam int FCQ_T_SETUP_NS = 20;
    localparam int FCQ_T_STROBE_NS = 70;
    localparam int FCQ_T_HOLD_NS = 30;
    localparam int FCQ_SETUP_CYC = (FCQ_T_SETUP_NS + FCQ_CLK_NS - 1) / FCQ_CLK_NS;
    localparam int FCQ_STROBE_CYC = (FCQ_T_STROBE_NS + FCQ_CLK_NS - 1) / FCQ_CLK_NS;
    localparam int FCQ_HOLD_CYC = (FCQ_T_HOLD_NS + FCQ_CLK_NS - 1) / FCQ_CLK_NS;
    localparam int FCQ_CNT_W = 4;
    // Command sequence addresses and codes
    localparam logic [15:0] FCQ_ADR_QRY_W = 16'h0055;
    localparam logic [15:0] FCQ_ADR_QRY_B = 16'h00AA;
    localparam logic [15:0] FCQ_ADR_UNL1_W = 16'h0555;
    localparam logic [15:0] FCQ_ADR_UNL1_B = 16'h0AAA;
    localparam logic [15:0] FCQ_ADR_UNL2_W = 16'h02AA;
    localparam logic [15:0] FCQ_ADR_UNL2_B = 16'h0555;
    localparam logic [15:0] FCQ_CMD_QUERY = 16'h0098;
    localparam logic [15:0] FCQ_CMD_RESET = 16'h00F0;
    localparam logic [15:0] FCQ_CMD_UNL1 = 16'h00AA;
    localparam logic [15:0] FCQ_CMD_UNL2 = 16'h0055;
    localparam logic [15:0] FCQ_CMD_PERS = 16'h0050;
    localparam logic [15:0] FCQ_CMD_DYN = 16'h00E0;
    localparam logic [15:0] FCQ_CMD_EXIT1 = 16'h0090;
    localparam logic [15:0] FCQ_CMD_EXIT2 = 16'h0000;
    localparam logic [7:0] FCQ_PROT_LOCKED = 8'h00;
    // Query locations (word addresses) and expected values
    localparam logic [7:0] FCQ_LOC_FIRST = 8'h10;
    localparam logic [7:0] FCQ_LOC_LAST = 8'h26;
    localparam logic [7:0] FCQ_LOC_ALT_FIRST = 8'h17;
    localparam logic [7:0] FCQ_LOC_ALT_LAST = 8'h1A;
    localparam logic [15:0] FCQ_Q_SIG0 = 16'h0051;
    localparam logic [15:0] FCQ_Q_SIG1 = 16'h0052;
    localparam logic [15:0] FCQ_Q_SIG2 = 16'h0059;
    localparam logic [15:0] FCQ_Q_EXT_PTR = 16'h0040;
    localparam logic [15:0] FCQ_Q_VCC_MIN = 16'h0027;
    localparam logic [15:0] FCQ_Q_VCC_MAX = 16'h0036;
    localparam logic [15:0] FCQ_Q_TYP_WR = 16'h0003;
    localparam logic [15:0] FCQ_Q_TYP_BUF = 16'h0006;
    localparam logic [15:0] FCQ_Q_TYP_BLK = 16'h0009;
    localparam logic [15:0] FCQ_Q_TYP_CHIP = 16'h0013;
    localparam logic [15:0] FCQ_Q_MAX_WR = 16'h0003;
    localparam logic [15:0] FCQ_Q_MAX_BUF = 16'h0005;
    localparam logic [15:0] FCQ_Q_MAX_BLK = 16'h0003;
    localparam logic [15:0] FCQ_Q_ZERO = 16'h0000;

    typedef enum logic [2:0] {
        FCQ_OP_READ = 3'b000,
        FCQ_OP_CFI_ENTER = 3'b001,
        FCQ_OP_CFI_EXIT = 3'b010,
        FCQ_OP_PROT_PERS = 3'b011,
        FCQ_OP_PROT_DYN = 3'b100,
        FCQ_OP_PROT_EXIT = 3'b101,
        FCQ_OP_PROT_STATUS = 3'b110,
        FCQ_OP_UNDEF = 3'b111
    } fcq_op_t;

    typedef enum logic [1:0] {
        FCQ_MODE_ARRAY = 2'b00,
        FCQ_MODE_QUERY = 2'b01,
        FCQ_MODE_PERS = 2'b10,
        FCQ_MODE_DYN = 2'b11
    } fcq_mode_t;

    typedef struct packed {
        fcq_op_t op;
        logic [FCQ_ADDR_W-1:0] addr;
    } fcq_req_t;

    typedef struct packed {
        logic [15:0] data;
        logic hi_clear;
        logic known;
        logic match;
        logic protected_sec;
    } fcq_rsp_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
    } fcq_pins_t;

    typedef struct packed {
        logic rd;
        logic last;
        logic [15:0] data;
        logic [FCQ_ADDR_W-1:0] addr;
    } fcq_step_t;
endpackage
`default_nettype wire

// File: hdl/fcq_bus_cycle.sv
// One asynchronous flash bus cycle (write or read) with timed phases.
// Assumes i_dq comes straight from the pins; it is synchronised here.
`default_nettype none
module fcq_bus_cycle
    import fcq_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_start,
    input wire logic i_write,
    input wire logic [FCQ_ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [15:0] i_dq,
    output logic o_done,
    output logic [15:0] o_rdata,
    output logic [FCQ_ADDR_W-1:0] o_addr,
    output logic [15:0] o_dq,
    output logic o_dq_oe_n,
    output fcq_pins_t o_pins
);
    typedef enum logic [1:0] {
        FCQ_BC_IDLE = 2'b00,
        FCQ_BC_SETUP = 2'b01,
        FCQ_BC_STROBE = 2'b10,
        FCQ_BC_HOLD = 2'b11
    } fcq_bc_state_t;

    initial begin
        if (FCQ_SETUP_CYC < 1 || FCQ_STROBE_CYC < 1 || FCQ_HOLD_CYC < 1 ||
            FCQ_STROBE_CYC >= (1 << FCQ_CNT_W)) begin
            $error("fcq_bus_cycle: phase counts out of range");
        end
    end

    localparam logic [FCQ_CNT_W-1:0] SETUP_LD = FCQ_CNT_W'(FCQ_SETUP_CYC - 1);
    localparam logic [FCQ_CNT_W-1:0] STROBE_LD = FCQ_CNT_W'(FCQ_STROBE_CYC - 1);
    localparam logic [FCQ_CNT_W-1:0] HOLD_LD = FCQ_CNT_W'(FCQ_HOLD_CYC - 1);

    fcq_bc_state_t state_q;
    logic [FCQ_CNT_W-1:0] cnt_q;
    logic wr_q;
    logic [15:0] s1_q, s2_q, s3_q;
    wire cnt_zero = (cnt_q == '0);
    // Read data counts only once the last two sync stages agree
    wire rd_stable = (s2_q == s3_q);

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1_q <= 16'h0000;
            s2_q <= 16'h0000;
            s3_q <= 16'h0000;
        end else begin
            s1_q <= i_dq;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= FCQ_BC_IDLE;
            cnt_q <= '0;
            wr_q <= 1'b0;
            o_done <= 1'b0;
            o_rdata <= 16'h0000;
            o_addr <= '0;
            o_dq <= 16'h0000;
            o_dq_oe_n <= 1'b1;
            o_pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
        end else begin
            o_done <= 1'b0;
            if (!cnt_zero) begin
                cnt_q <= cnt_q - 1'b1;
            end
            case (state_q)
                FCQ_BC_IDLE: begin
                    if (i_start) begin
                        wr_q <= i_write;
                        o_addr <= i_addr;
                        o_dq <= i_wdata;
                        o_dq_oe_n <= !i_write;
                        o_pins.ce_n <= 1'b0;
                        cnt_q <= SETUP_LD;
                        state_q <= FCQ_BC_SETUP;
                    end
                end
                FCQ_BC_SETUP: begin
                    if (cnt_zero) begin
                        o_pins.we_n <= !wr_q;
                        o_pins.oe_n <= wr_q;
                        cnt_q <= STROBE_LD;
                        state_q <= FCQ_BC_STROBE;
                    end
                end
                FCQ_BC_STROBE: begin
                    if (cnt_zero) begin
                        // Write data latches on the rising write strobe
                        o_pins.we_n <= 1'b1;
                        cnt_q <= HOLD_LD;
                        state_q <= FCQ_BC_HOLD;
                    end
                end
                FCQ_BC_HOLD: begin
                    if (cnt_zero && (wr_q || rd_stable)) begin
                        o_rdata <= s3_q;
                        o_done <= 1'b1;
                        o_dq_oe_n <= 1'b1;
                        o_pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
                        state_q <= FCQ_BC_IDLE;
                    end
                end
                default: begin
                    state_q <= FCQ_BC_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// File: hdl/fcq_host.sv
// Host controller that drives query and protection command sequences
// into an asynchronous parallel NOR flash and checks what comes back.
// Assumes the flash pins are wired directly; no other master on the bus.
//
// Behaviour
// (R01) Query entry: 98h to 55h/AAh
// (R02) Reset command leaves query mode
// (R03) Query data only on low lines
// (R04) Locations 10h-12h give the signature
// (R05) Byte address is twice word address
// (R06) 13h-14h command set id, 14h zero
// (R07) 15h-16h extended table pointer 0040/0000
// (R08) 17h-1Ah all read zero
// (R09) 1Bh/1Ch core supply 0027/0036
// (R10) 1Dh/1Eh read zero
// (R11) 1Fh-22h typical time exponents
// (R12) 23h-26h maximum time multipliers
// (R13) Protection status 00 protected, 01 not
// (R14) Never issue undefined command codes
// (R15) Undefined query locations are reserved
// (R16) Protect sets: unlock+50/E0, exit 90,00
`default_nettype none
module fcq_host
    import fcq_pkg::*;
#(
    parameter logic [15:0] CMDSET_ID = 16'h0007, // Arbitrary value
    parameter logic [15:0] CHIP_MULT_EXP = 16'h0000
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_byte_mode,
    input wire logic i_req_valid,
    input wire fcq_req_t i_req,
    output logic o_req_ready,
    output logic o_rejected,
    output logic o_rsp_valid,
    output fcq_rsp_t o_rsp,
    output fcq_mode_t o_mode,
    input wire logic [15:0] i_dq,
    output logic [15:0] o_dq,
    output logic o_dq_oe_n,
    output logic [FCQ_ADDR_W-1:0] o_addr,
    output fcq_pins_t o_pins
);
    initial begin
        if (CMDSET_ID[15:8] != 8'h00 || CHIP_MULT_EXP[15:8] != 8'h00) begin
            $error("fcq_host: query values must fit the low data lines");
        end
    end

    typedef enum logic [1:0] {
        FCQ_M_IDLE = 2'b00,
        FCQ_M_ISSUE = 2'b01,
        FCQ_M_WAIT = 2'b10
    } fcq_m_state_t;

    fcq_m_state_t state_q;
    fcq_mode_t mode_q;
    fcq_op_t op_q;
    logic [FCQ_ADDR_W-1:0] req_addr_q;
    logic [1:0] idx_q;
    logic byte_q;
    logic bc_done;
    logic [15:0] bc_rdata;

    // Sequence step for the current op and index
    function automatic fcq_step_t seq_step(input fcq_op_t op, input logic [1:0] idx,
                                           input logic bm, input fcq_mode_t md,
                                           input logic [FCQ_ADDR_W-1:0] a);
        fcq_step_t s;
        logic [15:0] unl1;
        logic [15:0] unl2;
        s = '{rd: 1'b0, last: 1'b1, data: 16'h0000, addr: '0};
        unl1 = bm ? FCQ_ADR_UNL1_B : FCQ_ADR_UNL1_W;
        unl2 = bm ? FCQ_ADR_UNL2_B : FCQ_ADR_UNL2_W;
        case (op)
            FCQ_OP_READ: begin
                s.rd = 1'b1;
                s.addr = (md == FCQ_MODE_QUERY && bm) ? (a << 1) : a; // R05
            end
            FCQ_OP_CFI_ENTER: begin
                s.addr = FCQ_ADDR_W'(bm ? FCQ_ADR_QRY_B : FCQ_ADR_QRY_W); // R01
                s.data = FCQ_CMD_QUERY; // R01
            end
            FCQ_OP_CFI_EXIT: begin
                s.data = FCQ_CMD_RESET; // R02
            end
            FCQ_OP_PROT_PERS, FCQ_OP_PROT_DYN: begin
                s.last = (idx == 2'd2);
                case (idx)
                    2'd0: begin
                        s.addr = FCQ_ADDR_W'(unl1);
                        s.data = FCQ_CMD_UNL1;
                    end
                    2'd1: begin
                        s.addr = FCQ_ADDR_W'(unl2);
                        s.data = FCQ_CMD_UNL2;
                    end
                    default: begin
                        s.addr = FCQ_ADDR_W'(unl1);
                        s.data = (op == FCQ_OP_PROT_PERS) ? FCQ_CMD_PERS : FCQ_CMD_DYN; // R16
                    end
                endcase
            end
            FCQ_OP_PROT_EXIT: begin
                s.last = (idx == 2'd1);
                s.data = (idx == 2'd0) ? FCQ_CMD_EXIT1 : FCQ_CMD_EXIT2; // R16
            end
            FCQ_OP_PROT_STATUS: begin
                s.rd = 1'b1;
                s.addr = a;
            end
            default: begin
                s.last = 1'b1;
            end
        endcase
        return s;
    endfunction

    // Expected query contents: {known, value}; unknown means reserved
    function automatic logic [16:0] query_expect(input logic [7:0] loc);
        logic [16:0] e;
        e = {1'b1, FCQ_Q_ZERO};
        case (loc)
            8'h10: e[15:0] = FCQ_Q_SIG0; // R04
            8'h11: e[15:0] = FCQ_Q_SIG1; // R04
            8'h12: e[15:0] = FCQ_Q_SIG2; // R04
            8'h13: e[15:0] = CMDSET_ID; // R06
            8'h14: e[15:0] = FCQ_Q_ZERO; // R06
            8'h15: e[15:0] = FCQ_Q_EXT_PTR; // R07
            8'h16: e[15:0] = FCQ_Q_ZERO; // R07
            8'h1B: e[15:0] = FCQ_Q_VCC_MIN; // R09
            8'h1C: e[15:0] = FCQ_Q_VCC_MAX; // R09
            8'h1D, 8'h1E: e[15:0] = FCQ_Q_ZERO; // R10
            8'h1F: e[15:0] = FCQ_Q_TYP_WR; // R11
            8'h20: e[15:0] = FCQ_Q_TYP_BUF; // R11
            8'h21: e[15:0] = FCQ_Q_TYP_BLK; // R11
            8'h22: e[15:0] = FCQ_Q_TYP_CHIP; // R11
            8'h23: e[15:0] = FCQ_Q_MAX_WR; // R12
            8'h24: e[15:0] = FCQ_Q_MAX_BUF; // R12
            8'h25: e[15:0] = FCQ_Q_MAX_BLK; // R12
            8'h26: e[15:0] = CHIP_MULT_EXP; // R12
            default: begin
                // R08 zero range; anything else is reserved
                e[16] = (loc >= FCQ_LOC_ALT_FIRST && loc <= FCQ_LOC_ALT_LAST); // R08 R15
            end
        endcase
        return e;
    endfunction

    // Legal ops per mode; undefined codes never reach the pins
    wire op_legal =
        (i_req.op == FCQ_OP_READ) ? (mode_q == FCQ_MODE_ARRAY || mode_q == FCQ_MODE_QUERY) :
        (i_req.op == FCQ_OP_CFI_ENTER) ? (mode_q == FCQ_MODE_ARRAY) : // R01
        (i_req.op == FCQ_OP_CFI_EXIT) ? (mode_q == FCQ_MODE_QUERY) : // R02
        (i_req.op == FCQ_OP_PROT_PERS || i_req.op == FCQ_OP_PROT_DYN) ?
            (mode_q == FCQ_MODE_ARRAY) :
        (i_req.op == FCQ_OP_PROT_EXIT || i_req.op == FCQ_OP_PROT_STATUS) ?
            (mode_q == FCQ_MODE_PERS || mode_q == FCQ_MODE_DYN) :
        1'b0; // R14
    wire accept = i_req_valid && (state_q == FCQ_M_IDLE);
    wire fcq_step_t step = seq_step(op_q, idx_q, byte_q, mode_q, req_addr_q);
    wire step_done = (state_q == FCQ_M_WAIT) && bc_done;
    wire query_rd = (op_q == FCQ_OP_READ) && (mode_q == FCQ_MODE_QUERY);
    wire [16:0] q_exp = query_expect(req_addr_q[7:0]);
    wire loc_in_range = (req_addr_q[FCQ_ADDR_W-1:8] == '0) &&
                        (req_addr_q[7:0] >= FCQ_LOC_FIRST) && (req_addr_q[7:0] <= FCQ_LOC_LAST);
    // High lines are ignored in query mode; the device holds them at zero
    wire [15:0] rsp_data = query_rd ? {8'h00, bc_rdata[7:0]} : bc_rdata; // R03
    wire rsp_known = query_rd && loc_in_range && q_exp[16]; // R15
    wire rsp_match = rsp_known && (bc_rdata[7:0] == q_exp[7:0]);
    wire rsp_prot = (op_q == FCQ_OP_PROT_STATUS) && (bc_rdata[7:0] == FCQ_PROT_LOCKED); // R13
    fcq_mode_t mode_d;

    assign mode_d =
        (op_q == FCQ_OP_CFI_ENTER) ? FCQ_MODE_QUERY : // R01
        (op_q == FCQ_OP_CFI_EXIT || op_q == FCQ_OP_PROT_EXIT) ? FCQ_MODE_ARRAY : // R02
        (op_q == FCQ_OP_PROT_PERS) ? FCQ_MODE_PERS : // R16
        (op_q == FCQ_OP_PROT_DYN) ? FCQ_MODE_DYN : mode_q;
    assign o_req_ready = (state_q == FCQ_M_IDLE);
    assign o_mode = mode_q;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= FCQ_M_IDLE;
            mode_q <= FCQ_MODE_ARRAY;
            op_q <= FCQ_OP_READ;
            req_addr_q <= '0;
            idx_q <= 2'd0;
            byte_q <= 1'b0;
            o_rejected <= 1'b0;
            o_rsp_valid <= 1'b0;
            o_rsp <= '0;
        end else begin
            o_rejected <= accept && !op_legal; // R14
            o_rsp_valid <= 1'b0;
            case (state_q)
                FCQ_M_IDLE: begin
                    if (accept && op_legal) begin
                        op_q <= i_req.op;
                        req_addr_q <= i_req.addr;
                        byte_q <= i_byte_mode;
                        idx_q <= 2'd0;
                        state_q <= FCQ_M_ISSUE;
                    end
                end
                FCQ_M_ISSUE: begin
                    state_q <= FCQ_M_WAIT;
                end
                FCQ_M_WAIT: begin
                    if (bc_done && step.last) begin
                        mode_q <= mode_d;
                        o_rsp_valid <= 1'b1;
                        o_rsp <= '{data: rsp_data, hi_clear: (bc_rdata[15:8] == 8'h00),
                                   known: rsp_known, match: rsp_match, protected_sec: rsp_prot};
                        state_q <= FCQ_M_IDLE;
                    end else if (bc_done) begin
                        idx_q <= idx_q + 2'd1;
                        state_q <= FCQ_M_ISSUE;
                    end
                end
                default: begin
                    state_q <= FCQ_M_IDLE;
                end
            endcase
        end
    end

    fcq_bus_cycle u_cycle (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_start(state_q == FCQ_M_ISSUE),
        .i_write(!step.rd),
        .i_addr(step.addr),
        .i_wdata(step.data),
        .i_dq(i_dq),
        .o_done(bc_done),
        .o_rdata(bc_rdata),
        .o_addr(o_addr),
        .o_dq(o_dq),
        .o_dq_oe_n(o_dq_oe_n),
        .o_pins(o_pins)
    );

    a_query_entry_addr: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R01
        (state_q == FCQ_M_ISSUE && op_q == FCQ_OP_CFI_ENTER) |=>
        (o_addr == FCQ_ADDR_W'(byte_q ? FCQ_ADR_QRY_B : FCQ_ADR_QRY_W)) && o_dq == FCQ_CMD_QUERY)
        else $error("query entry cycle has wrong address or code");
    a_query_mode_set: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R01
        (step_done && op_q == FCQ_OP_CFI_ENTER) |=> (mode_q == FCQ_MODE_QUERY))
        else $error("query mode not entered after entry command");
    a_reset_exit: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R02
        (state_q == FCQ_M_ISSUE && op_q == FCQ_OP_CFI_EXIT) |=>
        (o_dq == FCQ_CMD_RESET && !o_dq_oe_n) ##[1:20] (mode_q == FCQ_MODE_ARRAY))
        else $error("query exit did not send reset or return to array mode");
    a_hi_lines_masked: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R03
        (step_done && query_rd) |=> (o_rsp_valid && o_rsp.data[15:8] == 8'h00))
        else $error("query response carries high data lines");
    a_byte_addr_double: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R05
        (state_q == FCQ_M_ISSUE && query_rd && byte_q) |=>
        (o_addr == FCQ_ADDR_W'(req_addr_q << 1)) && !o_pins.ce_n)
        else $error("byte mode query address is not doubled");
    a_prot_status_code: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R13
        (step_done && op_q == FCQ_OP_PROT_STATUS) |=>
        (o_rsp.protected_sec == ($past(bc_rdata[7:0]) == FCQ_PROT_LOCKED)))
        else $error("protection status decoded wrongly");
    a_undef_refused: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R14
        (accept && i_req.op == FCQ_OP_UNDEF) |=> (o_rejected && state_q == FCQ_M_IDLE))
        else $error("undefined op was not refused");
    a_reserved_unknown: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R15
        (step_done && query_rd && !loc_in_range) |=> (o_rsp_valid && !o_rsp.known))
        else $error("reserved query location reported as known");
    a_signature_match: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R04
        (step_done && query_rd && req_addr_q == FCQ_ADDR_W'(8'h10) &&
         bc_rdata[7:0] == FCQ_Q_SIG0[7:0]) |=> (o_rsp.match && o_rsp.known))
        else $error("signature character not matched");
    a_prot_exit_pair: assert property (@(posedge i_clk) disable iff (!i_arst_n) // R16
        (state_q == FCQ_M_ISSUE && op_q == FCQ_OP_PROT_EXIT && idx_q == 2'd1) |=>
        (o_dq == FCQ_CMD_EXIT2) ##[1:20] (mode_q == FCQ_MODE_ARRAY))
        else $error("protection exit second cycle wrong");
endmodule
`default_nettype wire

// File: tb/fcq_flash_model.sv
// Behavioural flash model: command decoder, query table, protect status.
// Assumes the bench resolves the shared data lines and hands them in.
`default_nettype none
module fcq_flash_model
    import fcq_pkg::*;
#(
    parameter logic [15:0] CMDSET_ID = 16'h0007, // Arbitrary value
    parameter logic [15:0] CHIP_MULT_EXP = 16'h0000
) (
    input wire logic i_arst_n,
    input wire logic i_byte_mode,
    input wire logic [FCQ_ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_dq,
    input wire fcq_pins_t i_pins,
    output logic [15:0] o_dq
);
    timeunit 1ns;
    timeprecision 1ps;
    fcq_mode_t mode_q;
    logic [1:0] unl_q;
    logic exit_q;
    logic [15:0] last_a, last_d, rd_a, rd_val, u1, u2, a16;
    logic [15:0] last_q = 16'h0000;
    logic [7:0] loc;
    function automatic logic [7:0] qval(input logic [7:0] l);
        case (l)
            8'h10: return 8'h51;
            8'h11: return 8'h52;
            8'h12: return 8'h59;
            8'h13: return CMDSET_ID[7:0];
            8'h15: return 8'h40;
            8'h1B: return 8'h27;
            8'h1C: return 8'h36;
            8'h1F, 8'h23, 8'h25: return 8'h03;
            8'h20: return 8'h06;
            8'h21: return 8'h09;
            8'h22: return 8'h13;
            8'h24: return 8'h05;
            8'h26: return CHIP_MULT_EXP[7:0];
            8'h14, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1D, 8'h1E: return 8'h00;
            default: return 8'hA5;
        endcase
    endfunction
    assign a16 = i_addr[15:0];
    assign loc = i_byte_mode ? i_addr[8:1] : i_addr[7:0];
    assign u1 = i_byte_mode ? FCQ_ADR_UNL1_B : FCQ_ADR_UNL1_W;
    assign u2 = i_byte_mode ? FCQ_ADR_UNL2_B : FCQ_ADR_UNL2_W;
    always_comb begin
        case (mode_q)
            FCQ_MODE_QUERY: rd_val = {8'h00, qval(loc)};
            FCQ_MODE_PERS: rd_val = {15'h0000, ~i_addr[12]};
            FCQ_MODE_DYN: rd_val = {15'h0000, ~i_addr[13]};
            default: rd_val = a16;
        endcase
    end
    // Released lines show the inverse so a stale value never passes
    assign o_dq = (!i_pins.ce_n && !i_pins.oe_n) ? rd_val : ~last_q;
    always @(posedge i_pins.oe_n) last_q <= rd_val;
    always @(negedge i_pins.oe_n) rd_a <= a16;
    always @(posedge i_pins.we_n or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mode_q <= FCQ_MODE_ARRAY;
            unl_q <= 2'd0;
            exit_q <= 1'b0;
        end else if (!i_pins.ce_n) begin
            last_a <= a16;
            last_d <= i_dq;
            if (mode_q == FCQ_MODE_QUERY && i_dq == FCQ_CMD_RESET) begin
                mode_q <= FCQ_MODE_ARRAY;
            end else if (mode_q == FCQ_MODE_ARRAY && i_dq == FCQ_CMD_QUERY
                         && a16 == (i_byte_mode ? FCQ_ADR_QRY_B : FCQ_ADR_QRY_W)) begin
                mode_q <= FCQ_MODE_QUERY;
            end else if (mode_q[1] && i_dq == FCQ_CMD_EXIT1) begin
                exit_q <= 1'b1;
            end else if (exit_q && i_dq == FCQ_CMD_EXIT2) begin
                mode_q <= FCQ_MODE_ARRAY;
                exit_q <= 1'b0;
            end else if (unl_q == 2'd2 && a16 == u1
                         && (i_dq == FCQ_CMD_PERS || i_dq == FCQ_CMD_DYN)) begin
                mode_q <= (i_dq == FCQ_CMD_PERS) ? FCQ_MODE_PERS : FCQ_MODE_DYN;
                unl_q <= 2'd0;
            end else begin
                unl_q <= (i_dq == FCQ_CMD_UNL1 && a16 == u1) ? 2'd1 :
                         (unl_q == 2'd1 && i_dq == FCQ_CMD_UNL2 && a16 == u2) ? 2'd2 : 2'd0;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/test_flash_cfi_query_and_protect_cmds.sv
// Testbench for the query/protect host controller against a flash model.
// Assumes one 100 MHz clock; the data lines are resolved here.
`default_nettype none
module test_flash_cfi_query_and_protect_cmds import fcq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_arst_n = 0, byte_mode = 0, req_valid = 0, ready, rej, rsp_valid, hoe_n;
    fcq_req_t rq = '0;
    fcq_rsp_t rsp;
    fcq_mode_t mode;
    fcq_pins_t pins;
    logic [15:0] host_dq, flash_dq, dq;
    logic [FCQ_ADDR_W-1:0] addr;
    int n_fail = 0, check_count = 0;
    always #5 i_clk = ~i_clk;
    assign dq = hoe_n ? flash_dq : host_dq;
    fcq_host u_fcq_host (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_byte_mode(byte_mode),
        .i_req_valid(req_valid), .i_req(rq), .o_req_ready(ready), .o_rejected(rej),
        .o_rsp_valid(rsp_valid), .o_rsp(rsp), .o_mode(mode), .i_dq(dq), .o_dq(host_dq),
        .o_dq_oe_n(hoe_n), .o_addr(addr), .o_pins(pins));
    fcq_flash_model u_fcq_flash_model (.i_arst_n(i_arst_n), .i_byte_mode(byte_mode),
        .i_addr(addr), .i_dq(dq), .i_pins(pins), .o_dq(flash_dq));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic req(input fcq_op_t op, input logic [23:0] a, input logic exp_rej);
        int n;
        n = 0;
        @(negedge i_clk);
        while (ready !== 1'b1 && n < 50) begin
            @(negedge i_clk);
            n++;
        end
        req_valid = 1'b1;
        rq.op = op;
        rq.addr = a;
        @(negedge i_clk);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && rej !== 1'b1 && n < 200) begin
            @(negedge i_clk);
            n++;
        end
        // A missing answer lands here as a mismatch, not a silent pass
        check({14'h0000, rsp_valid, rej}, {14'h0000, !exp_rej, exp_rej});
    endtask
    task automatic t_reset;
        check({12'h000, pins, hoe_n}, 16'h000F);
        check({14'h0000, mode}, {14'h0000, FCQ_MODE_ARRAY});
    endtask
    task automatic t_refuse;
        req(FCQ_OP_UNDEF, 24'h00_0000, 1'b1);
        req(FCQ_OP_CFI_EXIT, 24'h00_0000, 1'b1);
        req(FCQ_OP_PROT_EXIT, 24'h00_0000, 1'b1);
        check({14'h0000, mode}, {14'h0000, FCQ_MODE_ARRAY});
    endtask
    task automatic t_query;
        req(FCQ_OP_CFI_ENTER, 24'h00_0000, 1'b0);
        check(u_fcq_flash_model.last_a, FCQ_ADR_QRY_W);
        check(u_fcq_flash_model.last_d, FCQ_CMD_QUERY);
        check({14'h0000, mode}, {14'h0000, FCQ_MODE_QUERY});
        for (int l = 16; l <= 38; l++) begin
            req(FCQ_OP_READ, 24'(l), 1'b0);
            check(rsp.data, {8'h00, u_fcq_flash_model.qval(8'(l))});
            check({13'h0000, rsp.hi_clear, rsp.known, rsp.match}, 16'h0007);
        end
        req(FCQ_OP_READ, 24'h00_0027, 1'b0);
        check({15'h0000, rsp.known}, 16'h0000);
        req(FCQ_OP_CFI_EXIT, 24'h00_0000, 1'b0);
        check(u_fcq_flash_model.last_d, FCQ_CMD_RESET);
        req(FCQ_OP_READ, 24'h00_0123, 1'b0);
        check(rsp.data, 16'h0123);
    endtask
    task automatic t_byte;
        byte_mode = 1'b1;
        req(FCQ_OP_CFI_ENTER, 24'h00_0000, 1'b0);
        check(u_fcq_flash_model.last_a, FCQ_ADR_QRY_B);
        req(FCQ_OP_READ, 24'h00_0012, 1'b0);
        check(u_fcq_flash_model.rd_a, 16'h0024);
        check(rsp.data, 16'h0059);
        req(FCQ_OP_CFI_EXIT, 24'h00_0000, 1'b0);
        byte_mode = 1'b0;
    endtask
    task automatic t_protect;
        fcq_op_t ops[2];
        logic [15:0] codes[2];
        ops = '{FCQ_OP_PROT_PERS, FCQ_OP_PROT_DYN};
        codes = '{FCQ_CMD_PERS, FCQ_CMD_DYN};
        for (int i = 0; i < 2; i++) begin
            req(ops[i], 24'h00_0000, 1'b0);
            check(u_fcq_flash_model.last_d, codes[i]);
            check({14'h0000, mode}, {14'h0000, 1'b1, 1'(i)});
            req(FCQ_OP_PROT_STATUS, 24'h00_1000 << i, 1'b0);
            check({rsp.data[14:0], rsp.protected_sec}, 16'h0001);
            req(FCQ_OP_PROT_STATUS, 24'h00_1000 << (1 - i), 1'b0);
            check({rsp.data[14:0], rsp.protected_sec}, 16'h0002);
            req(FCQ_OP_CFI_ENTER, 24'h00_0000, 1'b1);
            req(FCQ_OP_PROT_EXIT, 24'h00_0000, 1'b0);
            check(u_fcq_flash_model.last_d, FCQ_CMD_EXIT2);
            check({14'h0000, mode}, {14'h0000, FCQ_MODE_ARRAY});
        end
    endtask
    initial begin
        // Long enough for every sequence at roughly 14 clocks per bus cycle
        #200us;
        n_fail++;
        end_sim();
    end
    initial begin
        repeat (5) @(negedge i_clk);
        t_reset();
        i_arst_n = 1'b1;
        t_refuse();
        t_query();
        t_byte();
        t_protect();
        end_sim();
    end
endmodule
`default_nettype wire
